/* logic/rtc_unit.sv */
/*
  Range compare, table match and word compare execution unit.
  Assumes: issue_valid is a one-cycle pulse with issue_data steady in that
  cycle, only while busy is low; the word bus answers each read with one
  mem_rvalid pulse, in order, one read outstanding at a time.
*/
`timescale 1ns/1ps
`default_nettype none

// Contract
// RL1: Range compare idle when condition false
// RL2: Range block spans base through base plus 31
// RL3: Match when lower <= probe <= upper
// RL4: Pair n drives result bit n
// RL5: Unmatched bits written zero, whole word
// RL6: Program keeps lower limit <= upper limit
// RL7: Fault when range block passes area end
// RL8: Fault on bad indirect memory operand
// RL9: Table match idle when condition false
// RL10: Compare probe against sixteen table words
// RL11: Table offset k drives result bit k
// RL12: Fault when table passes area end
// RL13: Block base must be a memory word
// RL14: Program gives BCD against timer count
// RL15: Below flag exposed on dedicated output
// RL16: Below flag set when first less
// RL17: Unsigned compares, single result update
module rtc_unit (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic issue_valid,
  input wire rtc_pkg::rtc_issue_type issue_data,
  output logic busy,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_rvalid,
  input wire logic [15:0] mem_rdata,
  output rtc_pkg::rtc_done_type done_data,
  output logic below_flag
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rtc_pkg::rtc_state_type state_reg, state_next;
  rtc_pkg::rtc_op_type op_reg, op_next;     // Instruction in progress
  logic [15:0] probe_reg, probe_next;       // Probe value held for the run
  logic [15:0] base_reg, base_next;         // First block word address
  logic [5:0] index_reg, index_next;        // Word offset being fetched
  logic [5:0] count_reg, count_next;        // Words to fetch
  logic [15:0] lower_reg, lower_next;       // Lower limit of current pair
  logic [15:0] acc_reg, acc_next;           // Result built up privately
  logic busy_reg, busy_next;
  logic mem_req_reg, mem_req_next;
  logic [15:0] mem_addr_reg, mem_addr_next;
  rtc_pkg::rtc_done_type done_reg, done_next;
  logic below_reg, below_next;

  // Decoded per-entry hits for the word now on the bus
  logic [15:0] hit_vec;
  logic [3:0] entry_idx;

  // ----------------------------------------------------------------
  // Per-entry match decode
  // ----------------------------------------------------------------
  // Range pairs use index/2, table entries use the index itself
  assign entry_idx = (op_reg == rtc_pkg::rtc_op_range_compare) ? index_reg[4:1] : index_reg[3:0];

  // A comparator pair per bit, live only for the selected entry; unsigned operands throughout
  genvar gi;
  generate
    for (gi = 0; gi < rtc_pkg::entry_count; gi++) begin : g_hit
      always_comb begin
        hit_vec[gi] = 1'b0;
        if (entry_idx == 4'(gi)) begin
          if (op_reg == rtc_pkg::rtc_op_range_compare) begin
            hit_vec[gi] = (probe_reg >= lower_reg) && (probe_reg <= mem_rdata);  // [RL3] [RL4] [RL17]
          end else begin
            hit_vec[gi] = (probe_reg == mem_rdata);  // [RL10] [RL11] [RL17]
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Fault checks happen at issue so no stray reads reach memory
  always_comb begin
    logic [16:0] span_end;
    logic area_fault;
    span_end = 17'h00000;
    area_fault = 1'b0;
    state_next = state_reg;
    op_next = op_reg;
    probe_next = probe_reg;
    base_next = base_reg;
    index_next = index_reg;
    count_next = count_reg;
    lower_next = lower_reg;
    acc_next = acc_reg;
    busy_next = busy_reg;
    mem_req_next = 1'b0;
    mem_addr_next = mem_addr_reg;
    done_next = done_reg;
    done_next.done = 1'b0;
    done_next.result_write = 1'b0;
    below_next = below_reg;
    case (state_reg)
      rtc_pkg::rtc_st_idle: begin
        // Condition false: nothing compared, result and flags untouched
        if (issue_valid && issue_data.exec_cond) begin  // [RL1] [RL9]
          case (issue_data.op)
            rtc_pkg::rtc_op_word_compare: begin
              // Single-cycle compare; flags follow the latest compare
              below_next = issue_data.probe_value < issue_data.second_operand;  // [RL16] [RL15] [RL17]
              done_next.done = 1'b1;
              done_next.fault_flag = issue_data.indirect_fault;  // [RL8]
              done_next.below_flag = below_next;
              done_next.match_flag = issue_data.probe_value == issue_data.second_operand;
              done_next.above_flag = issue_data.probe_value > issue_data.second_operand;
            end
            rtc_pkg::rtc_op_range_compare, rtc_pkg::rtc_op_table_match: begin
              if (issue_data.op == rtc_pkg::rtc_op_range_compare) begin
                span_end = {1'b0, issue_data.block_base} + {1'b0, rtc_pkg::range_last_offset};  // [RL2]
              end else begin
                span_end = {1'b0, issue_data.block_base} + {1'b0, rtc_pkg::table_last_offset};  // [RL10]
              end
              // Block must fit inside its area; a carry out also means overflow
              area_fault = (span_end > {1'b0, issue_data.area_end});  // [RL7] [RL12]
              if (area_fault || issue_data.indirect_fault || issue_data.base_is_immediate) begin  // [RL8] [RL13]
                // Faulted instruction leaves the result word alone
                done_next.done = 1'b1;
                done_next.fault_flag = 1'b1;
              end else begin
                op_next = issue_data.op;
                probe_next = issue_data.probe_value;
                base_next = issue_data.block_base;
                index_next = 6'h00;
                count_next = (issue_data.op == rtc_pkg::rtc_op_range_compare) ?
                             rtc_pkg::range_words : rtc_pkg::table_words;
                acc_next = rtc_pkg::result_reset;  // [RL5]
                busy_next = 1'b1;
                state_next = rtc_pkg::rtc_st_fetch;
              end
            end
            default: begin
              // Unknown code: ignored
            end
          endcase
        end
      end
      rtc_pkg::rtc_st_fetch: begin
        // Issue one read for the current offset
        mem_req_next = 1'b1;
        mem_addr_next = base_reg + {10'h000, index_reg};
        state_next = rtc_pkg::rtc_st_wait;
      end
      rtc_pkg::rtc_st_wait: begin
        if (mem_rvalid) begin
          if ((op_reg == rtc_pkg::rtc_op_range_compare) && !index_reg[0]) begin
            lower_next = mem_rdata;  // Even offset holds the lower limit [RL2]
          end else begin
            acc_next = acc_reg | hit_vec;  // [RL4] [RL11]
          end
          index_next = index_reg + 6'h01;
          state_next = (index_next == count_reg) ? rtc_pkg::rtc_st_finish : rtc_pkg::rtc_st_fetch;
        end
      end
      rtc_pkg::rtc_st_finish: begin
        // Whole word written once, unmatched bits as zero
        done_next.done = 1'b1;
        done_next.result_write = 1'b1;  // [RL17] [RL5]
        done_next.result_word = acc_reg;
        done_next.fault_flag = 1'b0;
        busy_next = 1'b0;
        state_next = rtc_pkg::rtc_st_idle;
      end
      default: begin
        state_next = rtc_pkg::rtc_st_idle;
        busy_next = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= rtc_pkg::rtc_st_idle;
      op_reg <= rtc_pkg::rtc_op_none;
      probe_reg <= 16'h0000;
      base_reg <= 16'h0000;
      index_reg <= 6'h00;
      count_reg <= 6'h00;
      lower_reg <= 16'h0000;
      acc_reg <= rtc_pkg::result_reset;
      busy_reg <= 1'b0;
      mem_req_reg <= 1'b0;
      mem_addr_reg <= 16'h0000;
      done_reg <= '0;
      below_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      probe_reg <= probe_next;
      base_reg <= base_next;
      index_reg <= index_next;
      count_reg <= count_next;
      lower_reg <= lower_next;
      acc_reg <= acc_next;
      busy_reg <= busy_next;
      mem_req_reg <= mem_req_next;
      mem_addr_reg <= mem_addr_next;
      done_reg <= done_next;
      below_reg <= below_next;
    end
  end

  // Outputs straight from flip-flops
  assign busy = busy_reg;
  assign mem_req = mem_req_reg;
  assign mem_addr = mem_addr_reg;
  assign done_data = done_reg;
  assign below_flag = below_reg;

endmodule // rtc_unit

`default_nettype wire

/* logic/rtc_pkg.sv */
/*
  Package for the range and table compare unit: opcodes, operand and result
  carriers, sequencer state codes and fixed counts.
  Assumes a single controller clock and a sequencer that issues one
  instruction at a time.
*/
`default_nettype none

package rtc_pkg;

  // ----------------------------------------------------------------
  // Sizes and counts
  // ----------------------------------------------------------------
  localparam int unsigned word_width = 16;
  localparam int unsigned addr_width = 16;
  localparam int unsigned entry_count = 16;
  localparam logic [5:0] range_words = 6'h20;  // Lower/upper pairs
  localparam logic [5:0] table_words = 6'h10;  // One word per entry
  localparam logic [15:0] range_last_offset = 16'h001f;
  localparam logic [15:0] table_last_offset = 16'h000f;
  localparam logic [15:0] result_reset = 16'h0000;

  // ----------------------------------------------------------------
  // Instruction codes from the sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    rtc_op_word_compare = 2'h0,
    rtc_op_range_compare = 2'h1,
    rtc_op_table_match = 2'h2,
    rtc_op_none = 2'h3
  } rtc_op_type;

  // Instruction issue carrier
  typedef struct packed {
    rtc_op_type op;
    logic exec_cond;                     // Rung execution condition
    logic [word_width-1:0] probe_value;  // Already resolved operand
    logic [addr_width-1:0] block_base;   // Memory address of first word
    logic [addr_width-1:0] area_end;     // Last valid address of the area
    logic base_is_immediate;             // Illegal for block or table
    logic indirect_fault;                // Pointer not BCD or out of area
    logic [word_width-1:0] second_operand; // Word compare only
  } rtc_issue_type;

  // Completion carrier
  typedef struct packed {
    logic done;
    logic result_write;
    logic [word_width-1:0] result_word;
    logic fault_flag;
    logic below_flag;
    logic match_flag;
    logic above_flag;
  } rtc_done_type;

  // Sequencer states, Gray coded along idle, fetch, wait, finish
  typedef enum logic [1:0] {
    rtc_st_idle = 2'h0,
    rtc_st_fetch = 2'h1,
    rtc_st_wait = 2'h3,
    rtc_st_finish = 2'h2
  } rtc_state_type;

endpackage

`default_nettype wire

/* test/rtc_unit_monitor.sv */
/* Port checker for the compare unit.
   Assumes one clock mclk and rstn async active low. */
`timescale 1ns/1ps
`default_nettype none
module rtc_unit_monitor (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic issue_valid,
  input wire rtc_pkg::rtc_issue_type issue_data,
  input wire logic busy,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire rtc_pkg::rtc_done_type done_data,
  input wire logic below_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ----
  // Issue decode
  // ----
  wire logic take = issue_valid && !busy && issue_data.exec_cond;
  wire logic is_r = issue_data.op == rtc_pkg::rtc_op_range_compare;
  wire logic is_t = issue_data.op == rtc_pkg::rtc_op_table_match;
  // Carry kept so a base near the top still counts as overrun
  wire logic over_r = {1'b0, issue_data.block_base} + 17'h0001f > {1'b0, issue_data.area_end};
  wire logic over_t = {1'b0, issue_data.block_base} + 17'h0000f > {1'b0, issue_data.area_end};
  wire logic bad_op = issue_data.base_is_immediate || issue_data.indirect_fault;
  wire logic ok_blk = ((is_r && !over_r) || (is_t && !over_t)) && !bad_op;
  sequence s_word;
    take && issue_data.op == rtc_pkg::rtc_op_word_compare && !issue_data.indirect_fault;
  endsequence
  sequence s_fault_done;
    done_data.done && done_data.fault_flag && !done_data.result_write && !mem_req;
  endsequence
  // ----
  // Assertions
  // ----
  a_cond_off_quiet: assert property (issue_valid && !busy && !issue_data.exec_cond |=> !done_data.done)
    else $error("done after a disabled issue");
  a_word_answer: assert property (s_word |=> done_data.done && !done_data.fault_flag)
    else $error("word compare did not answer");
  a_below_value: assert property (s_word |=> below_flag ==
    ($past(issue_data.probe_value) < $past(issue_data.second_operand)))
    else $error("below flag wrong");
  a_range_over: assert property (take && is_r && over_r |=> s_fault_done)
    else $error("range overrun not faulted");
  a_table_over: assert property (take && is_t && over_t |=> s_fault_done)
    else $error("table overrun not faulted");
  a_bad_pointer: assert property (take && (is_r || is_t) && issue_data.indirect_fault |=> s_fault_done)
    else $error("bad pointer not faulted");
  a_imm_base: assert property (take && (is_r || is_t) && issue_data.base_is_immediate |=> s_fault_done)
    else $error("immediate base not faulted");
  a_write_at_end: assert property (done_data.result_write |-> done_data.done && !busy && !done_data.fault_flag)
    else $error("result written outside completion");
  a_first_read: assert property (take && ok_blk |-> ##2 mem_req && mem_addr == $past(issue_data.block_base, 2))
    else $error("first read not at base");
endmodule // rtc_unit_monitor
bind rtc_unit rtc_unit_monitor u_mon (.mclk, .rstn, .issue_valid, .issue_data, .busy, .mem_req, .mem_addr,
  .done_data, .below_flag);
`default_nettype wire

/* test/rtc_mem_model.sv */
/* Word memory behind the unit's read bus.
   Assumes one read outstanding; lat adds wait cycles. */
`timescale 1ns/1ps
`default_nettype none
module rtc_mem_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [1:0] lat,
  output logic mem_rvalid,
  output logic [15:0] mem_rdata
);
  logic [15:0] word_arr [0:63];  // Filled by the bench
  logic [1:0] cnt_reg;
  logic pend_reg;
  logic [5:0] adr_reg;
  // Answer lat plus one cycles after the request is seen; data toggles when not valid
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pend_reg <= 1'b0;
      cnt_reg <= 2'h0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 16'h0000;
    end else begin
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req) begin
        pend_reg <= 1'b1;
        cnt_reg <= lat;
        adr_reg <= mem_addr[5:0];
      end else if (pend_reg && cnt_reg != 2'h0) begin
        cnt_reg <= cnt_reg - 2'h1;
      end else if (pend_reg) begin
        pend_reg <= 1'b0;
        mem_rvalid <= 1'b1;
        mem_rdata <= word_arr[adr_reg];
      end
    end
  end
endmodule // rtc_mem_model
`default_nettype wire

/* test/testbench.sv */
/* Directed bench for the compare unit.
   Assumes the memory model and checker beside it. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic issue_valid = 1'b0;
  rtc_pkg::rtc_issue_type iss = '0;
  logic [1:0] lat = 2'h0;
  logic busy, mem_req, mem_rvalid, below_flag;
  logic [15:0] mem_addr, mem_rdata;
  rtc_pkg::rtc_done_type done_data;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  rtc_unit dut (.mclk, .rstn, .issue_valid, .issue_data(iss), .busy, .mem_req, .mem_addr,
    .mem_rvalid, .mem_rdata, .done_data, .below_flag);
  rtc_mem_model mem (.mclk, .rstn, .mem_req, .mem_addr, .lat, .mem_rvalid, .mem_rdata);
  initial forever #10 mclk = ~mclk;
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Mismatches %0d of %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One-cycle issue pulse; bad bit 0 immediate, bit 1 pointer
  task automatic issue(input rtc_pkg::rtc_op_type op, input logic c, input logic [15:0] p, b, e, s,
    input logic [1:0] bad);
    @(negedge mclk);
    iss = '{op, c, p, b, e, bad[0], bad[1], s};
    issue_valid = 1'b1;
    @(negedge mclk);
    issue_valid = 1'b0;
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    while (done_data.done !== 1'b1 && k < 400) begin
      @(negedge mclk);
      k++;
    end
    `CHK(done_data.done, 1'b1)
  endtask
  task automatic t_word();
    issue(rtc_pkg::rtc_op_word_compare, 1'b1, 16'h4000, 16'h0, 16'h0, 16'h5000, 2'h0);
    wait_done();
    `CHK({below_flag, done_data.below_flag, done_data.match_flag, done_data.above_flag}, 4'hc)
    issue(rtc_pkg::rtc_op_word_compare, 1'b1, 16'h5000, 16'h0, 16'h0, 16'h5000, 2'h0);
    wait_done();
    `CHK({below_flag, done_data.match_flag, done_data.above_flag}, 3'h2)
    // Greater probe through a bad pointer: flags still follow, fault raised
    issue(rtc_pkg::rtc_op_word_compare, 1'b1, 16'h6000, 16'h0, 16'h0, 16'h5000, 2'h2);
    wait_done();
    `CHK({below_flag, done_data.above_flag, done_data.fault_flag}, 3'h3)
  endtask
  // Reset in the middle of a table run clears busy, mem_req, below_flag and done_data
  task automatic t_reset();
    issue(rtc_pkg::rtc_op_word_compare, 1'b1, 16'h0100, 16'h0, 16'h0, 16'h0200, 2'h0);
    wait_done();
    issue(rtc_pkg::rtc_op_table_match, 1'b1, 16'h0280, 16'h0028, 16'h0037, 16'h0, 2'h0);
    repeat (3) @(negedge mclk);
    `CHK({busy, below_flag}, 2'h3)
    rstn = 1'b0;
    @(negedge mclk);
    `CHK({busy, mem_req, below_flag, done_data}, 25'h0000000)
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
  endtask
  // Block ends exactly at the area end
  task automatic t_blk(input logic tbl, input logic [15:0] p);
    logic [15:0] x;
    for (int n = 0; n < 16; n++)
      x[n] = tbl ? mem.word_arr[40+n] == p : mem.word_arr[8+2*n] <= p && p <= mem.word_arr[9+2*n];
    issue(tbl ? rtc_pkg::rtc_op_table_match : rtc_pkg::rtc_op_range_compare, 1'b1, p,
      tbl ? 16'h0028 : 16'h0008, tbl ? 16'h0037 : 16'h0027, 16'h0, 2'h0);
    wait_done();
    `CHK({done_data.result_write, done_data.fault_flag, busy}, 3'h4)
    `CHK(done_data.result_word, x)
  endtask
  task automatic t_off(input rtc_pkg::rtc_op_type op, input logic c);
    logic [15:0] old;
    logic seen;
    old = done_data.result_word;
    issue(op, c, 16'h0280, 16'h0008, 16'h0037, 16'h0, 2'h0);
    // A wrong answer would already stand in the cycle after the issue
    seen = done_data.done | mem_req;
    repeat (40) begin
      @(negedge mclk);
      seen |= done_data.done | mem_req;
    end
    `CHK({seen, done_data.result_word}, {1'b0, old})
  endtask
  task automatic t_fault(input rtc_pkg::rtc_op_type op, input logic [15:0] b, e, input logic [1:0] bad);
    logic [15:0] old;
    old = done_data.result_word;
    issue(op, 1'b1, 16'h0280, b, e, 16'h0, bad);
    wait_done();
    `CHK({done_data.fault_flag, done_data.result_write, done_data.result_word}, {2'h2, old})
  endtask
  initial begin
    for (int i = 0; i < 64; i++) mem.word_arr[i] = 16'(i * 3);
    for (int n = 0; n < 16; n++) begin
      mem.word_arr[8+2*n] = 16'(n * 256);
      mem.word_arr[9+2*n] = 16'(n * 256 + 128);
    end
    mem.word_arr[15] = 16'hffff;
    mem.word_arr[45] = 16'h0280;
    mem.word_arr[55] = 16'h0280;
    repeat (10) @(negedge mclk);
    rstn = 1'b1;
    t_word();
    t_blk(1'b0, 16'h0280);
    t_blk(1'b0, 16'h0500);
    lat = 2'h3;
    t_blk(1'b1, 16'h0280);
    t_off(rtc_pkg::rtc_op_range_compare, 1'b0);
    t_off(rtc_pkg::rtc_op_table_match, 1'b0);
    t_off(rtc_pkg::rtc_op_none, 1'b1);
    t_fault(rtc_pkg::rtc_op_range_compare, 16'h0009, 16'h0027, 2'h0);
    t_fault(rtc_pkg::rtc_op_table_match, 16'h0029, 16'h0037, 2'h0);
    t_fault(rtc_pkg::rtc_op_range_compare, 16'h0008, 16'h0027, 2'h1);
    t_fault(rtc_pkg::rtc_op_table_match, 16'h0028, 16'h0037, 2'h2);
    t_reset();
    t_word();
    t_blk(1'b1, 16'h0280);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
